// ### hdl/iog_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte-wide register port, 100 MHz board clock
// Notes: offsets are the printed register offsets
`ifndef IOG_CFG_SVH
`define IOG_CFG_SVH
`define IOG_OFS_PORT_A 8'h10
`define IOG_OFS_PORT_B 8'h11
`define IOG_OFS_PORT_C 8'h12
`define IOG_OFS_MODE_CMD 8'h13
`define IOG_OFS_BUF_FLOAT 8'h14
`define IOG_OFS_TRIG_CMD 8'h15
`define IOG_OFS_TRIG_EN 8'h16
`define IOG_OFS_CHG_FLAGS 8'h17
`define IOG_OFS_DAC_REF 8'h18
`define IOG_OFS_DAC0 8'h04
`define IOG_BIT_CLO_DIR 0
`define IOG_BIT_B_DIR 1
`define IOG_BIT_B_MODE 2
`define IOG_BIT_CHI_DIR 3
`define IOG_BIT_A_DIR 4
`define IOG_BIT_A_MODE_LO 5
`define IOG_BIT_A_MODE_HI 6
`define IOG_BIT_MODE_SET 7
`define IOG_BIT_DAC_TRIG 0
`define IOG_BIT_CONV_TRIG 1
`define IOG_CMD_RESET 8'h9B
`define IOG_TRIG_CMD_MASK 8'h1F
`define IOG_CLK_NS 10
`define IOG_PULSE_NS 1000
`define IOG_PULSE_CYC (`IOG_PULSE_NS / `IOG_CLK_NS)
`define IOG_DAC_CHANNELS 4
`endif

// ### hdl/iog_pkg.sv
// Purpose: types shared by the board glue register bank
// Assumes: nothing beyond the config header
// Notes: group A mode encoding is one-hot; command bits 6:5 select it
package iog_pkg;
   typedef enum logic [2:0] {
      IOG_GA_BASIC = 3'b001,
      IOG_GA_STROBED = 3'b010,
      IOG_GA_BIDIR = 3'b100
   } iog_ga_mode_t;
   typedef enum logic [2:0] {
      IOG_CNT_IDLE = 3'b001,
      IOG_CNT_RUN = 3'b010,
      IOG_CNT_LOW = 3'b100
   } iog_cnt_state_t;
endpackage

// ### hdl/iog_glue_regs.sv
// Purpose: board glue register bank behind byte-wide I/O registers
// Assumes: host strobes are one cycle and synchronous to sys_clk
// Notes: counter pulse width fixed at 1 us; period set by cnt_period
// How it works
// - trigger counter emits 1 us low pulses
// - conversion enable lets pulse start conversion
// - dac enable lets pulse update all dacs
// - stored conversion command keeps five low bits
// - triggered conversions use stored command only
// - ports A, B, C data at consecutive offsets
// - reads show pins if input, latch if output
// - reset makes all ports basic-mode inputs
// - port command register is write-only, eight bits
// - direction bits 0,1,3,4; one means input
// - bits 6:5 group A mode, 2 B, 7 flag
// - bit 6 set makes bit 5 ignored
// - buffer directions follow last command written
// - buffer control bit 0 enters float mode
// - float mode floats every port buffer a mode-set write sets as output
// - same command with bit 7 clear re-enables
// - change flag n sets on port C change
// - reading change flags returns and clears them
// - dac reference enable clears on every reset
// - dac trigger mode holds dac writes until pulse
// - port C change also flagged for status/interrupt
`timescale 1ns/1ps
`default_nettype none
`include "iog_cfg.svh"
module iog_glue_regs
   import iog_pkg::*;
#(
   parameter int DAC_N = `IOG_DAC_CHANNELS,
   parameter int PULSE_CYC = `IOG_PULSE_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [15:0] cnt_period,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   input wire logic [7:0] port_c_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_b_out,
   output logic [7:0] port_c_out,
   output logic port_a_oe,
   output logic port_b_oe,
   output logic port_c_hi_oe,
   output logic port_c_lo_oe,
   output logic [2:0] group_a_mode,
   output logic group_b_mode,
   output logic trigger_counter_n,
   output logic conv_start,
   output logic [7:0] conv_cmd,
   output logic [DAC_N*12-1:0] dac_value,
   output logic dac_reference_on,
   output logic port_c_changed
);
   localparam logic [15:0] PULSE_W = 16'(PULSE_CYC);
   logic [7:0] cmd_r;
   logic buffer_float_mode_r;
   logic [3:0] float_r;
   logic [4:0] trig_cmd_r;
   logic conversion_trigger_enable_r;
   logic dac_trigger_enable_r;
   logic [7:0] c_sync_r, c_prev_r, chg_flags_r;
   logic [15:0] cnt_r;
   iog_cnt_state_t cnt_st_r;
   logic tick;
   logic [DAC_N*12-1:0] dac_hold_r;
   logic [3:0] dir_in;
   logic wr_cmd, rd_chg;

   // a, b, c-hi, c-lo direction, one = input
   assign dir_in = {cmd_r[`IOG_BIT_A_DIR], cmd_r[`IOG_BIT_B_DIR],
                    cmd_r[`IOG_BIT_CHI_DIR], cmd_r[`IOG_BIT_CLO_DIR]};
   assign wr_cmd = clk_en && reg_wr && reg_addr == `IOG_OFS_MODE_CMD;
   assign rd_chg = clk_en && reg_rd && reg_addr == `IOG_OFS_CHG_FLAGS;
   assign tick = clk_en && cnt_st_r == IOG_CNT_RUN && cnt_r == 16'h0001;

   // command byte; reset gives basic-mode inputs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmd_r <= `IOG_CMD_RESET;
      end else if (wr_cmd && reg_wdata[`IOG_BIT_MODE_SET]) begin
         cmd_r <= reg_wdata;
      end else if (wr_cmd) begin
         cmd_r <= {1'b0, reg_wdata[6:0]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         buffer_float_mode_r <= 1'b0;
      end else if (clk_en && reg_wr && reg_addr == `IOG_OFS_BUF_FLOAT) begin
         buffer_float_mode_r <= reg_wdata[0];
      end
   end

   // float a port that becomes output under a mode-set write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         float_r <= 4'h0;
      end else if (wr_cmd) begin
         if (reg_wdata[`IOG_BIT_MODE_SET] && buffer_float_mode_r) begin
            float_r <= ~{reg_wdata[`IOG_BIT_A_DIR], reg_wdata[`IOG_BIT_B_DIR],
                         reg_wdata[`IOG_BIT_CHI_DIR],
                         reg_wdata[`IOG_BIT_CLO_DIR]};
         end else if (!reg_wdata[`IOG_BIT_MODE_SET]) begin
            float_r <= 4'h0;
         end
      end
   end

   // buffers drive only when output and not floated
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         {port_a_oe, port_b_oe, port_c_hi_oe, port_c_lo_oe} <= 4'h0;
      end else if (clk_en) begin
         {port_a_oe, port_b_oe, port_c_hi_oe, port_c_lo_oe} <=
            ~dir_in & ~float_r;
      end
   end

   // group modes; bit 6 overrides bit 5
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         group_a_mode <= IOG_GA_BASIC;
         group_b_mode <= 1'b0;
      end else if (clk_en) begin
         if (cmd_r[`IOG_BIT_A_MODE_HI]) begin
            group_a_mode <= IOG_GA_BIDIR;
         end else if (cmd_r[`IOG_BIT_A_MODE_LO]) begin
            group_a_mode <= IOG_GA_STROBED;
         end else begin
            group_a_mode <= IOG_GA_BASIC;
         end
         group_b_mode <= cmd_r[`IOG_BIT_B_MODE];
      end
   end

   // output latches; a mode-set clears them like the port unit does
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         port_a_out <= 8'h00;
         port_b_out <= 8'h00;
         port_c_out <= 8'h00;
      end else if (wr_cmd && reg_wdata[`IOG_BIT_MODE_SET]) begin
         port_a_out <= 8'h00;
         port_b_out <= 8'h00;
         port_c_out <= 8'h00;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `IOG_OFS_PORT_A: port_a_out <= reg_wdata;
            `IOG_OFS_PORT_B: port_b_out <= reg_wdata;
            `IOG_OFS_PORT_C: port_c_out <= reg_wdata;
            default: ;
         endcase
      end
   end

   // trigger enables and stored conversion command
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         trig_cmd_r <= 5'h00;
         conversion_trigger_enable_r <= 1'b0;
         dac_trigger_enable_r <= 1'b0;
         dac_reference_on <= 1'b0;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `IOG_OFS_TRIG_CMD: trig_cmd_r <= reg_wdata[4:0];
            `IOG_OFS_TRIG_EN: begin
               conversion_trigger_enable_r <= reg_wdata[`IOG_BIT_CONV_TRIG];
               dac_trigger_enable_r <= reg_wdata[`IOG_BIT_DAC_TRIG];
            end
            `IOG_OFS_DAC_REF: dac_reference_on <= reg_wdata[0];
            default: ;
         endcase
      end
   end

   // rate generator: low pulse of PULSE_CYC every cnt_period+1 cycles
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_st_r <= IOG_CNT_IDLE;
         cnt_r <= 16'h0000;
         trigger_counter_n <= 1'b1;
      end else if (clk_en) begin
         case (cnt_st_r)
            IOG_CNT_IDLE: begin
               trigger_counter_n <= 1'b1;
               if (cnt_period > PULSE_W) begin
                  cnt_st_r <= IOG_CNT_RUN;
                  cnt_r <= cnt_period - PULSE_W;
               end
            end
            IOG_CNT_RUN: begin
               if (cnt_r == 16'h0001) begin
                  cnt_st_r <= IOG_CNT_LOW;
                  cnt_r <= PULSE_W;
                  trigger_counter_n <= 1'b0;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            IOG_CNT_LOW: begin
               if (cnt_r == 16'h0001) begin
                  cnt_st_r <= IOG_CNT_IDLE;
                  trigger_counter_n <= 1'b1;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            default: cnt_st_r <= IOG_CNT_IDLE;
         endcase
      end
   end

   // pulse starts a conversion with the stored command only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         conv_start <= 1'b0;
         conv_cmd <= 8'h00;
      end else if (clk_en) begin
         conv_start <= tick && conversion_trigger_enable_r;
         if (tick && conversion_trigger_enable_r) begin
            conv_cmd <= {3'b000, trig_cmd_r};
         end
      end
   end

   // dac staging; in trigger mode all outputs move on the pulse
   genvar g;
   generate
      for (g = 0; g < DAC_N; g++) begin : g_dac
         localparam logic [7:0] LO = 8'(`IOG_OFS_DAC0 + 2 * g);
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               dac_hold_r[g*12 +: 12] <= 12'h000;
               dac_value[g*12 +: 12] <= 12'h000;
            end else if (clk_en) begin
               if (reg_wr && reg_addr == LO) begin
                  dac_hold_r[g*12 +: 8] <= reg_wdata;
               end else if (reg_wr && reg_addr == LO + 8'h01) begin
                  dac_hold_r[g*12+8 +: 4] <= reg_wdata[3:0];
               end
               if (dac_trigger_enable_r) begin
                  if (tick) begin
                     dac_value[g*12 +: 12] <= dac_hold_r[g*12 +: 12];
                  end
               end else begin
                  dac_value[g*12 +: 12] <= dac_hold_r[g*12 +: 12];
               end
            end
         end
      end
   endgenerate

   // port C sampled and compared each cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         c_sync_r <= 8'hFF;
         c_prev_r <= 8'hFF;
      end else if (clk_en) begin
         c_sync_r <= port_c_in;
         c_prev_r <= c_sync_r;
      end
   end

   // sticky flags; new change wins over the clearing read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         chg_flags_r <= 8'h00;
         port_c_changed <= 1'b0;
      end else if (clk_en) begin
         chg_flags_r <= (rd_chg ? 8'h00 : chg_flags_r) |
                        (c_sync_r ^ c_prev_r);
         port_c_changed <= |(c_sync_r ^ c_prev_r);
      end
   end

   // read mux: pins when input, latch when output
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en && reg_rd) begin
         case (reg_addr)
            `IOG_OFS_PORT_A: reg_rdata <= dir_in[3] ? port_a_in : port_a_out;
            `IOG_OFS_PORT_B: reg_rdata <= dir_in[2] ? port_b_in : port_b_out;
            `IOG_OFS_PORT_C: reg_rdata <=
               {dir_in[1] ? port_c_in[7:4] : port_c_out[7:4],
                dir_in[0] ? port_c_in[3:0] : port_c_out[3:0]};
            `IOG_OFS_BUF_FLOAT: reg_rdata <= {7'h00, buffer_float_mode_r};
            `IOG_OFS_CHG_FLAGS: reg_rdata <= chg_flags_r;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   a_pulse_width: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(trigger_counter_n) && clk_en |->
      !trigger_counter_n [*2])
      else $error("trigger pulse too short");
   a_conv_start: assert property (@(posedge sys_clk) disable iff (rst)
      conv_start |-> conversion_trigger_enable_r && conv_cmd[7:5] == 3'b000)
      else $error("conversion started without enable");
   a_chg_keep: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && (c_sync_r != c_prev_r) |=> chg_flags_r != 8'h00)
      else $error("port C change lost");
   a_ref_reset: assert property (@(posedge sys_clk)
      $past(rst) |-> !dac_reference_on)
      else $error("dac reference on after reset");
   // port A made output by a mode-set write while floating
   sequence s_float_cmd;
      wr_cmd && reg_wdata[`IOG_BIT_MODE_SET] && buffer_float_mode_r &&
      !reg_wdata[`IOG_BIT_A_DIR] ##1 clk_en;
   endsequence
   a_float_out: assert property (@(posedge sys_clk) disable iff (rst)
      s_float_cmd |=> !port_a_oe)
      else $error("floated port buffer still driven");
   a_conv_cmd: assert property (@(posedge sys_clk) disable iff (rst)
      tick && conversion_trigger_enable_r ##1 clk_en |->
      conv_start && conv_cmd == {3'b000, $past(trig_cmd_r)})
      else $error("triggered conversion used wrong command");
endmodule
`default_nettype wire

// ### test/iog_pin_model.sv
// Purpose: port pin model, pull-ups plus an outside driver on port C
// Assumes: the outside driver never fights an enabled buffer
// Notes: undriven lines read high, so a stale value never shows
`timescale 1ns/1ps
`default_nettype none
module iog_pin_model (
   input wire logic [7:0] a_out,
   input wire logic [7:0] b_out,
   input wire logic [7:0] c_out,
   input wire logic a_oe,
   input wire logic b_oe,
   input wire logic chi_oe,
   input wire logic clo_oe,
   input wire logic [7:0] ext_c,
   input wire logic ext_en,
   output logic [7:0] a_in,
   output logic [7:0] b_in,
   output logic [7:0] c_in
);
   logic [7:0] c_far;
   assign c_far = ext_en ? ext_c : 8'hFF;
   assign a_in = a_oe ? a_out : 8'hFF;
   assign b_in = b_oe ? b_out : 8'hFF;
   assign c_in[7:4] = chi_oe ? c_out[7:4] : c_far[7:4];
   assign c_in[3:0] = clo_oe ? c_out[3:0] : c_far[3:0];
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Purpose: register-level bench for the glue register bank
// Assumes: one-cycle host strobes, clk_en held high
// Notes: counter period kept short to limit run time
`timescale 1ns/1ps
`default_nettype none
`include "iog_cfg.svh"
`define TB_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
   mismatches++; $display("Error at %0t: got %h exp %h", $time, g, e); \
   end end
module tb_top;
   import iog_pkg::*;
   localparam int PW = 100;
   logic sys_clk = 0;
   logic rst = 1;
   logic wr = 0;
   logic rd = 0;
   logic ext_en = 0;
   logic [7:0] addr = 0, wdata = 0, ext_c = 0, rdata, v, lastcmd;
   logic [15:0] period = 0;
   logic [7:0] a_in, b_in, c_in, a_out, b_out, c_out, cmd;
   logic a_oe, b_oe, chi_oe, clo_oe, gb, tcn, cs, dref;
   logic [2:0] ga;
   logic [47:0] dac;
   int mismatches = 0;
   int comparisons = 0;
   int cyc = 0;
   int ncv = 0;
   int npc = 0;
   int kc;
   logic pcc;
   int n, k;
   logic [7:0] ct [4] = '{8'h80, 8'h8A, 8'h91, 8'h9B};
   logic [3:0] et [4] = '{4'hF, 4'h9, 4'h6, 4'h0};
   logic [7:0] gm [3] = '{8'hA0, 8'hC0, 8'hE0};
   logic [2:0] ge [3] = '{IOG_GA_STROBED, IOG_GA_BIDIR, IOG_GA_BIDIR};
   always #5 sys_clk = ~sys_clk;
   iog_glue_regs #(.DAC_N(4), .PULSE_CYC(PW)) dut (.sys_clk(sys_clk),
      .rst(rst), .clk_en(1'b1), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .cnt_period(period),
      .port_a_in(a_in), .port_b_in(b_in), .port_c_in(c_in),
      .port_a_out(a_out), .port_b_out(b_out), .port_c_out(c_out),
      .port_a_oe(a_oe), .port_b_oe(b_oe), .port_c_hi_oe(chi_oe),
      .port_c_lo_oe(clo_oe), .group_a_mode(ga), .group_b_mode(gb),
      .trigger_counter_n(tcn), .conv_start(cs), .conv_cmd(cmd),
      .dac_value(dac), .dac_reference_on(dref), .port_c_changed(pcc));
   iog_pin_model pins (.a_out(a_out), .b_out(b_out), .c_out(c_out),
      .a_oe(a_oe), .b_oe(b_oe), .chi_oe(chi_oe), .clo_oe(clo_oe),
      .ext_c(ext_c), .ext_en(ext_en), .a_in(a_in), .b_in(b_in),
      .c_in(c_in));
   // conv_start lasts one cycle, so it is caught here, not polled
   always @(posedge sys_clk) begin
      if (cs === 1'b1) begin
         ncv <= ncv + 1;
         lastcmd <= cmd;
      end
      if (pcc === 1'b1) begin
         npc <= npc + 1;
      end
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 12000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int t);
      repeat (t) @(posedge sys_clk);
      #1;
   endtask
   task automatic do_rst;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      tick(1);
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic setc(input logic [7:0] d);
      @(posedge sys_clk);
      ext_c <= d;
      tick(4);
   endtask
   // waits for a counter pulse, returns its low width in cycles
   task automatic wait_low(output int w);
      w = 0;
      for (int i = 0; i < 400 && tcn !== 1'b0; i++) tick(1);
      while (tcn === 1'b0 && w < 400) begin
         w++;
         tick(1);
      end
   endtask
   initial begin
      do_rst();
      `TB_CHK(tcn, 1'b1)
      `TB_CHK(ga, IOG_GA_BASIC)
      `TB_CHK({a_oe, b_oe, chi_oe, clo_oe}, 4'h0)
      `TB_CHK(dref, 1'b0)
      rd8(`IOG_OFS_PORT_A, v);
      `TB_CHK(v, 8'hFF)
      rd8(`IOG_OFS_MODE_CMD, v);
      `TB_CHK(v, 8'h00)
      rd8(8'h20, v);
      `TB_CHK(v, 8'h00)
      for (int i = 0; i < 4; i++) begin
         wr8(`IOG_OFS_MODE_CMD, ct[i]);
         tick(2);
         `TB_CHK({a_oe, b_oe, chi_oe, clo_oe}, et[i])
      end
      wr8(`IOG_OFS_MODE_CMD, 8'h80);
      for (int i = 0; i < 3; i++) begin
         wr8(8'(`IOG_OFS_PORT_A + i), 8'(8'hA5 ^ i));
         rd8(8'(`IOG_OFS_PORT_A + i), v);
         `TB_CHK(v, 8'(8'hA5 ^ i))
      end
      `TB_CHK(b_out, 8'hA4)
      for (int i = 0; i < 3; i++) begin
         wr8(`IOG_OFS_MODE_CMD, gm[i]);
         tick(2);
         `TB_CHK(ga, ge[i])
      end
      wr8(`IOG_OFS_MODE_CMD, 8'h84);
      tick(2);
      `TB_CHK(gb, 1'b1)
      wr8(`IOG_OFS_BUF_FLOAT, 8'h01);
      rd8(`IOG_OFS_BUF_FLOAT, v);
      `TB_CHK(v, 8'h01)
      wr8(`IOG_OFS_MODE_CMD, 8'h80);
      tick(2);
      `TB_CHK({a_oe, b_oe, chi_oe, clo_oe}, 4'h0)
      `TB_CHK(a_in, 8'hFF)
      wr8(`IOG_OFS_PORT_A, 8'h3C);
      wr8(`IOG_OFS_MODE_CMD, 8'h00);
      tick(2);
      `TB_CHK({a_oe, b_oe, chi_oe, clo_oe}, 4'hF)
      `TB_CHK(a_in, 8'h3C)
      wr8(`IOG_OFS_BUF_FLOAT, 8'h00);
      wr8(`IOG_OFS_MODE_CMD, 8'h80);
      tick(2);
      `TB_CHK({a_oe, b_oe, chi_oe, clo_oe}, 4'hF)
      wr8(`IOG_OFS_MODE_CMD, `IOG_CMD_RESET);
      ext_en <= 1'b1;
      setc(8'h50);
      rd8(`IOG_OFS_CHG_FLAGS, v);
      kc = npc;
      setc(8'h40);
      setc(8'h60);
      rd8(`IOG_OFS_CHG_FLAGS, v);
      `TB_CHK(v, 8'h30)
      rd8(`IOG_OFS_CHG_FLAGS, v);
      `TB_CHK(v, 8'h00)
      for (int i = 0; i < 3; i++) setc(ext_c ^ 8'h01);
      rd8(`IOG_OFS_CHG_FLAGS, v);
      `TB_CHK(v, 8'h01)
      `TB_CHK(npc - kc, 5)
      wr8(`IOG_OFS_TRIG_CMD, 8'hFF);
      wr8(`IOG_OFS_TRIG_EN, 8'h03);
      wr8(`IOG_OFS_DAC0, 8'h34);
      wr8(`IOG_OFS_DAC0 + 8'h01, 8'h02);
      tick(3);
      `TB_CHK(dac[11:0], 12'h000)
      @(posedge sys_clk);
      period <= 16'd300;
      wait_low(n);
      `TB_CHK(n, PW)
      `TB_CHK(dac[11:0], 12'h234)
      `TB_CHK(ncv, 1)
      `TB_CHK(lastcmd, 8'h1F)
      wr8(`IOG_OFS_TRIG_CMD, 8'hE5);
      wait_low(n);
      `TB_CHK(lastcmd, 8'h05)
      wr8(`IOG_OFS_TRIG_EN, 8'h00);
      k = ncv;
      wait_low(n);
      tick(3);
      `TB_CHK(ncv, k)
      period <= 16'd0;
      wr8(`IOG_OFS_DAC_REF, 8'h01);
      tick(2);
      `TB_CHK(dref, 1'b1)
      do_rst();
      `TB_CHK(dref, 1'b0)
      report_and_stop();
   end
endmodule
`default_nettype wire
